// file: verilog/sbpm_defines.vh
`ifndef SBPM_DEFINES_VH
`define SBPM_DEFINES_VH
// ----------------------------------------
// Personality straps and pin codes
// ----------------------------------------
`define SBPM_MODE_ISA 2'h0
`define SBPM_MODE_LBUS 2'h1
`define SBPM_MODE_CARD 2'h2
`define SBPM_DACK_CARD 3'h4
`define SBPM_SA_RESET_IN 20'hFFF00
`define SBPM_SA_RESET_OUT 20'hFFF03
`define SBPM_BOOT_ADDR 24'hFFFFF0
`define SBPM_OWN_BUS 3'h1
`define SBPM_OWN_IDE 3'h2
`define SBPM_OWN_SWITCH 3'h4
`define SBPM_SYNC_SETTLE 3'h4
`endif

// file: verilog/sbpm_sync.v
`timescale 1ns/10ps
`include "sbpm_defines.vh"
module sbpm_sync (
  // Clock and reset
  input wire ref_clk,
  input wire rst,
  // Pin in, filtered level out
  input wire pin_in,
  output reg level_r
);
  reg s1_r;
  reg s2_r;
  reg s3_r;
  // Three stages; change accepted once stages two and three agree
  always @(posedge ref_clk) begin
    if (rst) begin
      s1_r <= 1'b1;
      s2_r <= 1'b1;
      s3_r <= 1'b1;
      level_r <= 1'b1;
    end else begin
      s1_r <= pin_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        level_r <= s3_r;
      end
    end
  end
endmodule

// file: verilog/sbpm_arbiter.v
`timescale 1ns/10ps
`include "sbpm_defines.vh"
module sbpm_arbiter (
  // Clock and reset
  input wire ref_clk,
  input wire rst,
  // Cycle requests and activity
  input wire ide_req,
  input wire bus_req,
  input wire cycle_busy,
  // Ownership
  output wire ide_owner,
  output wire ide_grant,
  output wire bus_grant
);
  localparam ST_BUS = `SBPM_OWN_BUS;
  localparam ST_IDE = `SBPM_OWN_IDE;
  localparam ST_SW = `SBPM_OWN_SWITCH;
  reg [2:0] state_r;
  reg [2:0] state_nxt;
  reg target_r;
  reg target_nxt;
  // One dead cycle on each hand-over lets the transceiver turn
  always @* begin
    state_nxt = state_r;
    target_nxt = target_r;
    case (state_r)
      ST_BUS: begin
        if (ide_req && !bus_req && !cycle_busy) begin // [RL2] [RL15]
          state_nxt = ST_SW;
          target_nxt = 1'b1;
        end
      end
      ST_IDE: begin
        if (!ide_req && !cycle_busy) begin // [RL15]
          state_nxt = ST_SW;
          target_nxt = 1'b0;
        end
      end
      ST_SW: begin
        state_nxt = target_r ? ST_IDE : ST_BUS;
      end
      default: begin
        state_nxt = ST_BUS;
      end
    endcase
  end
  always @(posedge ref_clk) begin
    if (rst) begin
      state_r <= ST_BUS;
      target_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      target_r <= target_nxt;
    end
  end
  assign ide_owner = (state_r == ST_IDE) || (state_r == ST_SW && target_r);
  assign ide_grant = (state_r == ST_IDE);
  assign bus_grant = (state_r == ST_BUS);
endmodule

// file: verilog/sbpm_top.v
`timescale 1ns/10ps
`include "sbpm_defines.vh"
// Summary of operation
// RL1 - Straps pick one personality: ISA, local bus or card; fixed while running.
// RL2 - Chosen bus shares pins with IDE, handed over cycle by cycle; code keeps IDE off the pins in local bus mode.
// RL3 - Transceiver enable high for IDE, low for ISA/card; select 3 in local mode.
// RL4 - IDE data 11..0 on address 19..8; disk address, selects on upper lines.
// RL5 - Card mode: DMA acknowledge code fixed at 4, ISA-only strobes zero.
// RL6 - Request code pins carry card byte enables, or local address 21..20.
// RL7 - ISA floats other-mode pins; card uses them for detect, local for selects 5,4.
// RL8 - After reset in ISA or card mode, first prefetch starts at FFFFF0.
// RL9 - Address pins FFF03 after reset input release while reset output active.
// RL10 - Drive selects low once reset input is released.
// RL11 - In reset, card enables and supply enables high, programming controls low.
// RL12 - In reset, local byte enables and flash selects high.
// RL13 - Transceiver enable isolates IDE data pins from ISA address pins.
// RL14 - Outside logic NANDs each drive select with transceiver enable.
// RL15 - Ownership changes only between complete bus cycles.
module sbpm_top (
  // Clock and reset
  input wire ref_clk,
  input wire rst,
  // System reset pins and personality straps
  input wire system_reset_in_n,
  input wire system_reset_out_n,
  input wire [1:0] strap_mode,
  // Bus-side controller request
  input wire bus_req,
  input wire bus_busy,
  input wire [23:0] bus_addr,
  input wire [1:0] card_byte_en_n,
  input wire [1:0] local_addr_hi,
  input wire isa_strobe,
  input wire [2:0] isa_dack_code,
  // IDE-side controller request
  input wire ide_req,
  input wire ide_busy,
  input wire [11:0] disk_data,
  input wire [2:0] disk_addr,
  input wire [3:0] drive_select,
  input wire [1:0] local_select_hi_n,
  // Card detect pins
  input wire card_present_a_n,
  input wire card_present_b_n,
  // Shared address pins
  output reg [19:0] system_addr_bus,
  output reg [6:0] latched_upper_addr,
  // Ownership and DMA code pins
  output reg transceiver_oe_n,
  output reg [2:0] dma_ack_code,
  output reg isa_strobe_out,
  output reg [1:0] dma_request_code,
  // Dual-use select pins (output enable low while driven)
  output reg [1:0] select_pair_out,
  output reg select_pair_oe_n,
  // Card and local bus controls
  output reg card_5v_supply_en,
  output reg card_3v_supply_en,
  output reg prog_voltage_select,
  output reg [1:0] local_byte_en_n,
  output reg flash_select_0_n,
  // Status to controllers
  output reg [1:0] mode_r,
  output wire ide_grant,
  output wire bus_grant,
  output reg [1:0] card_present_r
);
  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  wire rst_in_n_s;
  wire rst_out_n_s;
  wire cd_a_s;
  wire cd_b_s;
  // System reset input pin
  sbpm_sync u_sync_ri (
    .ref_clk(ref_clk),
    .rst(rst),
    .pin_in(system_reset_in_n),
    .level_r(rst_in_n_s)
  );
  // System reset output pin
  sbpm_sync u_sync_ro (
    .ref_clk(ref_clk),
    .rst(rst),
    .pin_in(system_reset_out_n),
    .level_r(rst_out_n_s)
  );
  // Card detect pin A
  sbpm_sync u_sync_ca (
    .ref_clk(ref_clk),
    .rst(rst),
    .pin_in(card_present_a_n),
    .level_r(cd_a_s)
  );
  // Card detect pin B
  sbpm_sync u_sync_cb (
    .ref_clk(ref_clk),
    .rst(rst),
    .pin_in(card_present_b_n),
    .level_r(cd_b_s)
  );

  // ----------------------------------------
  // Synchroniser settle window
  // ----------------------------------------
  reg [2:0] settle_cnt_r;
  wire settled;
  // Sync stages wake at the idle level; hold reset state until they track the pins
  always @(posedge ref_clk) begin
    if (rst) begin
      settle_cnt_r <= 3'h0;
    end else if (!settled) begin
      settle_cnt_r <= settle_cnt_r + 3'h1;
    end
  end
  assign settled = (settle_cnt_r == `SBPM_SYNC_SETTLE);

  // ----------------------------------------
  // Personality decode
  // ----------------------------------------
  // Strap code compare, shared by arbitration and detect gating
  function mode_is;
    input [1:0] mode;
    input [1:0] code;
    begin
      mode_is = (mode == code);
    end
  endfunction
  wire mode_lbus;
  wire mode_card;
  assign mode_lbus = mode_is(mode_r, `SBPM_MODE_LBUS);
  assign mode_card = mode_is(mode_r, `SBPM_MODE_CARD);

  // ----------------------------------------
  // Strap capture
  // ----------------------------------------
  wire in_reset;
  wire in_boot;
  assign in_reset = rst || !settled || !rst_in_n_s;
  assign in_boot = settled && rst_in_n_s && !rst_out_n_s;
  // Straps sampled only while system reset is held, so mode never moves later
  always @(posedge ref_clk) begin
    if (rst) begin
      mode_r <= `SBPM_MODE_ISA;
    end else if (!rst_out_n_s) begin
      if (strap_mode == `SBPM_MODE_LBUS || strap_mode == `SBPM_MODE_CARD) begin
        mode_r <= strap_mode; // [RL1]
      end else begin
        mode_r <= `SBPM_MODE_ISA; // [RL1]
      end
    end
  end

  // ----------------------------------------
  // Ownership arbiter
  // ----------------------------------------
  wire ide_owner;
  wire any_busy;
  wire hold_arb;
  // Local bus has no IDE sharing on these pins; keep IDE out during reset
  assign any_busy = bus_busy || ide_busy;
  assign hold_arb = in_reset || !rst_out_n_s || mode_lbus;
  sbpm_arbiter u_arb (
    .ref_clk(ref_clk),
    .rst(rst),
    .ide_req(ide_req && !hold_arb),
    .bus_req(bus_req),
    .cycle_busy(any_busy),
    .ide_owner(ide_owner),
    .ide_grant(ide_grant),
    .bus_grant(bus_grant)
  );

  // ----------------------------------------
  // Pin steering
  // ----------------------------------------
  reg [19:0] sa_nxt;
  reg [6:0] la_nxt;
  reg oe_nxt;
  reg [2:0] dack_nxt;
  reg strobe_nxt;
  reg [1:0] dreq_nxt;
  reg [1:0] sel_nxt;
  reg sel_oe_nxt;
  reg v5_nxt;
  reg v3_nxt;
  reg vpp_nxt;
  reg [1:0] pbe_nxt;
  reg fcs_nxt;
  reg first_fetch_r;
  // Boot vector split over the low address pins and the upper latched lines
  wire [23:0] boot_addr;
  assign boot_addr = `SBPM_BOOT_ADDR;
  // All pins registered so each hand-over lands cleanly on one edge
  always @* begin
    sa_nxt = bus_addr[19:0];
    la_nxt = bus_addr[23:17];
    oe_nxt = 1'b0; // [RL3] [RL13]
    dack_nxt = isa_dack_code;
    strobe_nxt = isa_strobe;
    dreq_nxt = card_byte_en_n;
    sel_nxt = 2'h3;
    sel_oe_nxt = 1'b1; // [RL7]
    v5_nxt = 1'b0;
    v3_nxt = 1'b0;
    vpp_nxt = 1'b0;
    pbe_nxt = 2'h3;
    fcs_nxt = 1'b1;
    if (mode_r == `SBPM_MODE_LBUS) begin
      oe_nxt = local_select_hi_n[0]; // [RL3]
      dreq_nxt = local_addr_hi; // [RL6]
      sel_nxt = local_select_hi_n; // [RL7]
      sel_oe_nxt = 1'b0;
      pbe_nxt = card_byte_en_n;
      fcs_nxt = 1'b0;
    end else if (mode_r == `SBPM_MODE_CARD) begin
      dack_nxt = `SBPM_DACK_CARD; // [RL5]
      strobe_nxt = 1'b0; // [RL5]
      dreq_nxt = card_byte_en_n; // [RL6]
      v5_nxt = 1'b1;
      v3_nxt = 1'b1;
    end
    // IDE overlay on the ISA and card pins
    if (ide_owner && mode_r != `SBPM_MODE_LBUS) begin
      oe_nxt = 1'b1; // [RL3] [RL13]
      sa_nxt[19:8] = disk_data; // [RL4]
      la_nxt = {drive_select, disk_addr}; // [RL4]
    end
    // Boot vector is a bus cycle, so it never covers IDE data on the pins
    if (first_fetch_r && !ide_owner) begin
      sa_nxt = boot_addr[19:0]; // [RL8]
      la_nxt = boot_addr[23:17];
    end
    // Reset states win over everything above
    if (in_boot) begin
      sa_nxt = `SBPM_SA_RESET_OUT; // [RL9]
      la_nxt = 7'h00; // [RL10]
      oe_nxt = 1'b1;
    end
    if (in_reset) begin
      sa_nxt = `SBPM_SA_RESET_IN; // [RL9]
      oe_nxt = 1'b1;
      strobe_nxt = 1'b0;
      v5_nxt = 1'b1; // [RL11]
      v3_nxt = 1'b1; // [RL11]
      vpp_nxt = 1'b0; // [RL11]
      dreq_nxt = (mode_r == `SBPM_MODE_CARD) ? 2'h3 : dreq_nxt; // [RL11]
      pbe_nxt = 2'h3; // [RL12]
      fcs_nxt = 1'b1; // [RL12]
    end
  end

  // ----------------------------------------
  // Boot fetch flag
  // ----------------------------------------
  // Set while reset output holds after reset input release (not local mode), cleared on first granted bus request
  always @(posedge ref_clk) begin
    if (rst) begin
      first_fetch_r <= 1'b0;
    end else if (in_boot && mode_r != `SBPM_MODE_LBUS) begin
      first_fetch_r <= 1'b1; // [RL8]
    end else if (bus_req && bus_grant) begin
      first_fetch_r <= 1'b0;
    end
  end

  // ----------------------------------------
  // Registered pin outputs
  // ----------------------------------------
  always @(posedge ref_clk) begin
    if (rst) begin
      system_addr_bus <= `SBPM_SA_RESET_IN;
      latched_upper_addr <= 7'h00;
      transceiver_oe_n <= 1'b1;
      dma_ack_code <= 3'h0;
      isa_strobe_out <= 1'b0;
      dma_request_code <= 2'h3;
      select_pair_out <= 2'h3;
      select_pair_oe_n <= 1'b1;
      card_5v_supply_en <= 1'b1;
      card_3v_supply_en <= 1'b1;
      prog_voltage_select <= 1'b0;
      local_byte_en_n <= 2'h3;
      flash_select_0_n <= 1'b1;
      card_present_r <= 2'h3;
    end else begin
      system_addr_bus <= sa_nxt;
      latched_upper_addr <= la_nxt;
      transceiver_oe_n <= oe_nxt;
      dma_ack_code <= dack_nxt;
      isa_strobe_out <= strobe_nxt;
      dma_request_code <= dreq_nxt;
      select_pair_out <= sel_nxt;
      select_pair_oe_n <= sel_oe_nxt;
      card_5v_supply_en <= v5_nxt;
      card_3v_supply_en <= v3_nxt;
      prog_voltage_select <= vpp_nxt;
      local_byte_en_n <= pbe_nxt;
      flash_select_0_n <= fcs_nxt;
      // Card detect only meaningful in card mode
      card_present_r <= mode_card ? {cd_b_s, cd_a_s} : 2'h3; // [RL7]
    end
  end
endmodule

// file: bench/sbpm_far_side.sv
`timescale 1ns/10ps
// ----------------------------------------
// Socket and drive side of the shared pins
// ----------------------------------------
module sbpm_far_side (
  // Pins from the device
  input wire transceiver_oe_n,
  input wire [6:0] latched_upper_addr,
  input wire [1:0] select_pair_out,
  input wire select_pair_oe_n,
  // Socket state from the bench
  input wire card_in,
  // Pins back to the device and to the drives
  output wire card_present_a_n,
  output wire card_present_b_n,
  output wire [3:0] drive_sel_n
);
  // Pulled up; a seated card grounds both, a driven select wins
  assign card_present_a_n = !select_pair_oe_n ? select_pair_out[1] : !card_in;
  assign card_present_b_n = !select_pair_oe_n ? select_pair_out[0] : !card_in;
  // Gate so a drive is picked only while the transceiver isolates ISA
  assign drive_sel_n = ~(latched_upper_addr[6:3] & {4{transceiver_oe_n}});
endmodule

// file: bench/sbpm_top_asserts.sv
`timescale 1ns/10ps
`include "sbpm_defines.vh"
module sbpm_checker (
  // Clock, reset, pins in
  input wire ref_clk,
  input wire rst,
  input wire system_reset_in_n,
  input wire system_reset_out_n,
  input wire bus_busy,
  input wire ide_busy,
  input wire [11:0] disk_data,
  input wire [2:0] disk_addr,
  input wire [3:0] drive_select,
  input wire [1:0] card_byte_en_n,
  input wire [1:0] local_addr_hi,
  // Pins out
  input wire [19:0] system_addr_bus,
  input wire [6:0] latched_upper_addr,
  input wire transceiver_oe_n,
  input wire [2:0] dma_ack_code,
  input wire isa_strobe_out,
  input wire [1:0] dma_request_code,
  input wire select_pair_oe_n,
  input wire card_5v_supply_en,
  input wire card_3v_supply_en,
  input wire prog_voltage_select,
  input wire [1:0] local_byte_en_n,
  input wire flash_select_0_n,
  input wire [1:0] mode_r,
  input wire ide_grant,
  input wire bus_grant
);
  default clocking dc @(posedge ref_clk); endclocking
  default disable iff (rst);
  // Long enough for the pin synchronisers to settle
  sequence s_run;
    (system_reset_in_n && system_reset_out_n)[*8];
  endsequence
  sequence s_hold;
    (system_reset_in_n && !system_reset_out_n)[*8];
  endsequence
  sequence s_ide;
    ide_grant && $past(ide_grant) && $stable({disk_data, disk_addr, drive_select});
  endsequence
  grant_excl_a: assert property (!(ide_grant && bus_grant))
    else $error("both owners granted");
  rst_card_a: assert property ($fell(rst) |-> card_5v_supply_en && card_3v_supply_en
    && !prog_voltage_select) else $error("card controls wrong after reset");
  rst_local_a: assert property ($fell(rst) |-> local_byte_en_n == 2'h3
    && flash_select_0_n) else $error("local selects wrong after reset");
  pin_hold_a: assert property (s_hold |-> system_addr_bus == `SBPM_SA_RESET_OUT
    && latched_upper_addr == 7'h00 && transceiver_oe_n) else $error("reset hold pins wrong");
  ide_pins_a: assert property (s_ide |-> system_addr_bus[19:8] == disk_data
    && latched_upper_addr == {drive_select, disk_addr}) else $error("ide pins wrong");
  ide_oe_a: assert property (s_ide |-> transceiver_oe_n)
    else $error("transceiver open in ide");
  bus_oe_a: assert property (s_run ##0 (mode_r != `SBPM_MODE_LBUS) && bus_grant
    && $past(bus_grant) |-> !transceiver_oe_n) else $error("transceiver shut for bus");
  bus_busy_a: assert property (bus_grant && bus_busy |=> !ide_grant)
    else $error("ide took pins mid cycle");
  ide_busy_a: assert property (ide_grant && ide_busy |=> ide_grant)
    else $error("ide lost pins mid cycle");
  card_dack_a: assert property (s_run ##0 (mode_r == `SBPM_MODE_CARD) |->
    dma_ack_code == `SBPM_DACK_CARD && !isa_strobe_out) else $error("card dack wrong");
  req_code_a: assert property (s_run ##0 $stable({card_byte_en_n, local_addr_hi}) |->
    dma_request_code == (mode_r == `SBPM_MODE_CARD ? card_byte_en_n :
    mode_r == `SBPM_MODE_LBUS ? local_addr_hi : dma_request_code)) else $error("req code");
  float_a: assert property (s_run ##0 (mode_r != `SBPM_MODE_LBUS) |-> select_pair_oe_n)
    else $error("select pair driven");
endmodule
bind sbpm_top sbpm_checker chk (.*);

// file: bench/shared_bus_pin_multiplexer_test.sv
`timescale 1ns/10ps
`include "sbpm_defines.vh"
module shared_bus_pin_multiplexer_test;
  reg ref_clk, rst, system_reset_in_n, system_reset_out_n, bus_req, bus_busy, isa_strobe;
  reg ide_req, ide_busy, card_in;
  reg [1:0] strap_mode, card_byte_en_n, local_addr_hi, local_select_hi_n;
  reg [23:0] bus_addr;
  reg [2:0] isa_dack_code, disk_addr;
  reg [11:0] disk_data;
  reg [3:0] drive_select;
  reg [31:0] r;
  wire card_present_a_n, card_present_b_n, transceiver_oe_n, isa_strobe_out, select_pair_oe_n;
  wire card_5v_supply_en, card_3v_supply_en, prog_voltage_select, flash_select_0_n;
  wire ide_grant, bus_grant;
  wire [19:0] system_addr_bus;
  wire [6:0] latched_upper_addr;
  wire [2:0] dma_ack_code;
  wire [1:0] dma_request_code, select_pair_out, local_byte_en_n, mode_r, card_present_r;
  wire [3:0] drive_sel_n;
  integer err_total, total_checks, k, m;
  sbpm_top dut (.*);
  sbpm_far_side far (.*);
  // ----------------------------------------
  // Clock, helpers, expectations
  // ----------------------------------------
  initial begin
    ref_clk = 0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  function [1:0] exp_mode(input [1:0] s);
    exp_mode = (s == 2'h3) ? `SBPM_MODE_ISA : s;
  endfunction
  task step(input integer n);
    repeat (n) @(posedge ref_clk);
    #2;
  endtask
  task chk(input [159:0] what, input [23:0] exp, input [23:0] got);
    total_checks = total_checks + 1;
    if (got !== exp) begin
      err_total = err_total + 1;
      $display("BAD %0s exp %h got %h", what, exp, got);
    end
  endtask
  task end_sim;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Full pin reset sequence, then strap capture
  task boot(input [1:0] s);
    {rst, system_reset_in_n, system_reset_out_n, bus_req, ide_req, bus_busy, ide_busy} = 7'h40;
    strap_mode = s;
    step(5);
    chk("reset ctl", 6'h37, {card_5v_supply_en, card_3v_supply_en, prog_voltage_select,
      local_byte_en_n, flash_select_0_n});
    rst = 0;
    step(3);
    system_reset_in_n = 1;
    step(10);
    chk("hold addr", `SBPM_SA_RESET_OUT, system_addr_bus);
    chk("drive sel", 0, latched_upper_addr);
    system_reset_out_n = 1;
    step(10);
    chk("mode", exp_mode(s), mode_r);
    if (exp_mode(s) != `SBPM_MODE_LBUS) begin
      chk("boot addr", `SBPM_BOOT_ADDR & 24'h0FFFFF, system_addr_bus);
      chk("oe bus", 0, transceiver_oe_n);
    end
    strap_mode = ~s;
    step(6);
    chk("mode held", exp_mode(s), mode_r);
  endtask
  // Handover both ways outside local mode, each blocked by a busy cycle first; local mode checks IDE stays out
  task ide_xfer(input [1:0] s);
    r = $urandom;
    {disk_data, disk_addr, drive_select} = r[18:0];
    {bus_busy, bus_req, ide_req} = 3'h5;
    step(6);
    chk("grant busy", 0, ide_grant);
    bus_busy = 0;
    for (k = 0; k < 10 && ide_grant !== 1'b1; k++) step(1);
    step(2);
    if (exp_mode(s) == `SBPM_MODE_LBUS)
      chk("lbus grant", 0, ide_grant);
    else begin
      chk("ide data", disk_data, system_addr_bus[19:8]);
      chk("ide upper", {drive_select, disk_addr}, latched_upper_addr);
      chk("oe ide", 1, transceiver_oe_n);
      chk("drive gate", {~drive_select}, drive_sel_n);
      {ide_busy, ide_req, bus_req} = 3'h5;
      step(4);
      chk("ide held", 1, ide_grant);
      ide_busy = 0;
      for (k = 0; k < 10 && bus_grant !== 1'b1; k++) step(1);
      step(2);
      chk("oe back", 0, transceiver_oe_n);
    end
    {ide_req, bus_req} = 2'h0;
  endtask
  // Card detect and dual-use selects once straps are fixed
  task side_pins(input [1:0] s);
    card_in = 1;
    local_select_hi_n = 2'h2;
    step(8);
    chk("card detect", (exp_mode(s) == `SBPM_MODE_CARD) ? 2'h0 : 2'h3, card_present_r);
    chk("select oe", (exp_mode(s) == `SBPM_MODE_LBUS) ? 1'b0 : 1'b1, select_pair_oe_n);
    if (exp_mode(s) == `SBPM_MODE_LBUS) begin
      chk("select pair", 2'h2, select_pair_out);
      chk("select 3", 1'b0, transceiver_oe_n);
    end
    card_in = 0;
    step(8);
    chk("card gone", 2'h3, card_present_r);
  endtask
  // Random contention; the checker judges every cycle
  task traffic;
    repeat (60) begin
      r = $urandom;
      {bus_req, bus_busy, ide_req, ide_busy, isa_strobe, card_in} = r[5:0];
      r = $urandom;
      {bus_addr, card_byte_en_n, local_addr_hi, local_select_hi_n} = r[29:0];
      r = $urandom;
      {isa_dack_code, disk_addr, disk_data, drive_select} = r[21:0];
      step(1 + $urandom % 3);
    end
  endtask
  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial begin
    {rst, system_reset_in_n, system_reset_out_n, bus_req, bus_busy, isa_strobe} = 6'h20;
    {ide_req, ide_busy, card_in, strap_mode, card_byte_en_n, local_addr_hi} = 9'h0;
    {local_select_hi_n, bus_addr, isa_dack_code, disk_addr, disk_data, drive_select} = 0;
    err_total = 0;
    total_checks = 0;
    r = $urandom(32'hDF4F);
    for (m = 0; m < 4; m++) begin
      boot(m[1:0]);
      side_pins(m[1:0]);
      ide_xfer(m[1:0]);
      traffic;
      $display("test strap %0d done", m);
    end
    end_sim;
  end
  initial begin
    #(25 * 5000);
    err_total = err_total + 1;
    $display("BAD watchdog exp done got hang");
    end_sim;
  end
endmodule
